// ==== bench/test_uart_receive_status.sv ====
/*
 * self-checking bench of the receive status block.
 * assumes the transmitter model and the register map of the defs header.
 */
`timescale 1ns/100ps
`default_nettype none

`include "urs_defs.svh"

module test_uart_receive_status
	import urs_pkg::*;
;
	logic        clk, rst, ce, rxd, wr, rd, irq;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	int          mismatches, total_checks;

	urs_top urs_top_inst (.clk(clk), .rst(rst), .ce(ce), .rxd(rxd), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	urs_tx_model #(.BIT_DIV(4)) urs_tx_model_inst (.clk(clk), .rxd(rxd));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(what, exp, rdata);
	endtask

	task automatic irq_chk(input logic exp);
		@(negedge clk);
		chk("irq", {15'h0, exp}, {15'h0, irq});
	endtask

	task automatic send(input logic [8:0] d, input logic [1:0] f, input logic bp, input logic bs);
		urs_tx_model_inst.send(d, f, bp, bs);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		rchk(`URS_OFS_STATUS, 16'h0010, "status after reset");
		rchk(`URS_OFS_MODE, 16'h0000, "format after reset");
		rchk(`URS_OFS_BIT_DIV, `URS_RST_BIT_DIV, "bit period after reset");
		wr_reg(`URS_OFS_STATUS, 16'h0002);
		rchk(`URS_OFS_STATUS, 16'h0010, "overrun set by write");
		wr_reg(8'h1c, 16'hffff);
		rchk(8'h1c, 16'h0000, "unmapped read");
		wr_reg(`URS_OFS_BIT_DIV, 16'h0004);
		rchk(`URS_OFS_BIT_DIV, 16'h0004, "bit period");
	endtask

	// clock enable low: a write strobe must not land
	task automatic t_freeze;
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(`URS_OFS_MODE, 16'h0003);
		ce <= 1'b1;
		rchk(`URS_OFS_MODE, 16'h0000, "write while frozen");
	endtask

	// every format, with a bad parity bit where parity exists
	task automatic t_formats;
		for (int f = 0; f < 4; f++) begin
			for (int bp = 0; bp < ((f == 1 || f == 2) ? 2 : 1); bp++) begin
				wr_reg(`URS_OFS_MODE, 16'(f));
				send(9'h1a5, 2'(f), 1'(bp), 1'b0);
				rchk(`URS_OFS_STATUS, bp ? 16'h0019 : 16'h0011, "status format");
				rchk(`URS_OFS_RX_DATA, {7'h0, f == 3, 8'ha5}, "data format");
				rchk(`URS_OFS_STATUS, 16'h0010, "status drained");
			end
		end
	endtask

	// idle flag drops while a frame is on the line
	task automatic t_idle;
		wr_reg(`URS_OFS_MODE, 16'h0000);
		fork
			send(9'h03c, 2'h0, 1'b0, 1'b0);
			begin
				repeat (12) @(posedge clk);
				rchk(`URS_OFS_STATUS, 16'h0000, "status mid frame");
			end
		join
		rchk(`URS_OFS_RX_DATA, 16'h003c, "data after idle");
	endtask

	// broken stop bit, then a clean character behind it; interrupt path
	task automatic t_frame;
		wr_reg(`URS_OFS_INT_STS, 16'h0007);
		send(9'h03c, 2'h0, 1'b0, 1'b1);
		send(9'h05a, 2'h0, 1'b0, 1'b0);
		irq_chk(1'b0);
		rchk(`URS_OFS_STATUS, 16'h0015, "status framing");
		rchk(`URS_OFS_RX_DATA, 16'h003c, "bad frame data");
		rchk(`URS_OFS_STATUS, 16'h0011, "status next head");
		rchk(`URS_OFS_RX_DATA, 16'h005a, "good frame data");
		rchk(`URS_OFS_INT_STS, 16'h0005, "event status");
		wr_reg(`URS_OFS_INT_MASK, 16'h0004);
		irq_chk(1'b1);
		wr_reg(`URS_OFS_INT_STS, 16'h0004);
		irq_chk(1'b0);
		wr_reg(`URS_OFS_INT_MASK, 16'h0000);
	endtask

	// five characters into four places
	task automatic t_overrun;
		wr_reg(`URS_OFS_INT_STS, 16'h0007);
		for (int i = 0; i < 5; i++) send(9'(i), 2'h0, 1'b0, 1'b0);
		rchk(`URS_OFS_STATUS, 16'h0013, "status overrun");
		rchk(`URS_OFS_INT_STS, 16'h0003, "overrun event");
		wr_reg(`URS_OFS_STATUS, 16'h0002);
		rchk(`URS_OFS_STATUS, 16'h0013, "overrun kept");
		wr_reg(`URS_OFS_STATUS, 16'h0000);
		rchk(`URS_OFS_STATUS, 16'h0010, "status after clear");
		rchk(`URS_OFS_RX_DATA, 16'h0000, "empty read");
		send(9'h066, 2'h0, 1'b0, 1'b0);
		rchk(`URS_OFS_RX_DATA, 16'h0066, "data after clear");
	endtask

	// address detect only acts in nine-bit format
	task automatic t_addr;
		wr_reg(`URS_OFS_MODE, 16'h0003);
		wr_reg(`URS_OFS_STATUS, 16'h0020);
		send(9'h055, 2'h3, 1'b0, 1'b0);
		rchk(`URS_OFS_STATUS, 16'h0030, "data char dropped");
		send(9'h1aa, 2'h3, 1'b0, 1'b0);
		rchk(`URS_OFS_RX_DATA, 16'h01aa, "address char");
		wr_reg(`URS_OFS_MODE, 16'h0000);
		send(9'h077, 2'h0, 1'b0, 1'b0);
		rchk(`URS_OFS_STATUS, 16'h0031, "detect off in 8 bit");
		rchk(`URS_OFS_RX_DATA, 16'h0077, "8 bit char");
		wr_reg(`URS_OFS_STATUS, 16'h0000);
	endtask

	// ************************************************************
	// clock, reset, sequence and watchdog
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_freeze();
		t_formats();
		t_idle();
		t_frame();
		t_overrun();
		t_addr();
		report_and_stop();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
endmodule

`default_nettype wire

// ==== bench/urs_tx_model.sv ====
/*
 * remote serial transmitter model that drives the receive line.
 * assumes the block samples each bit every bit_div+1 clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module urs_tx_model #(
	parameter int BIT_DIV = 4 // bit period in clocks, minus one
) (
	input  wire logic clk, // peripheral clock
	output logic      rxd  // serial line, idles high
);
	// ************************************************************
	// frame sender
	// ************************************************************
	initial rxd = 1'b1;

	// one bit held a whole period, changed just after an edge
	task automatic put(input logic b);
		rxd <= b;
		repeat (BIT_DIV + 1) @(posedge clk);
	endtask

	// fmt picks width and parity; bad_par and bad_stop break the frame
	task automatic send(input logic [8:0] d, input logic [1:0] fmt,
			input logic bad_par, input logic bad_stop);
		@(posedge clk);
		put(1'b0);
		for (int i = 0; i < ((fmt == 2'h3) ? 9 : 8); i++) put(d[i]);
		if (fmt == 2'h1) put(^d[7:0] ^ bad_par);
		if (fmt == 2'h2) put(~^d[7:0] ^ bad_par);
		put(~bad_stop);
		// a full idle bit, so a broken stop is not taken for a start
		put(1'b1);
	endtask
endmodule

`default_nettype wire

// ==== pkg/urs_defs.svh ====
/*
 * register offsets, field positions and reset values of the
 * receive status block. assumes 8-bit byte addresses on a 16-bit register port.
 */
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH

// ************************************************************
// register map
// ************************************************************
`define URS_OFS_STATUS   8'h00
`define URS_OFS_MODE     8'h04
`define URS_OFS_INT_STS  8'h08
`define URS_OFS_INT_MASK 8'h0c
`define URS_OFS_RX_DATA  8'h10
`define URS_OFS_BIT_DIV  8'h14

// ************************************************************
// status and control fields
// ************************************************************
`define URS_ST_ADDRESS_DETECT_ENABLE  5
`define URS_ST_RECEIVER_IDLE_FLAG  4
`define URS_ST_PARITY_ERROR_FLAG   3
`define URS_ST_FRAMING_ERROR_FLAG   2
`define URS_ST_OVERRUN_ERROR_FLAG   1
`define URS_ST_AVAIL  0

// interrupt status and mask fields
`define URS_INT_RXCHAR 0
`define URS_INT_OVRUN  1
`define URS_INT_CHERR  2

// ************************************************************
// reset values
// ************************************************************
`define URS_RST_MODE    2'h0
`define URS_RST_BIT_DIV 16'h0056
`define URS_RST_MASK    3'h0

`endif

// ==== pkg/urs_pkg.sv ====
/*
 * types shared by the receive status block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package urs_pkg;

	// ************************************************************
	// data and parity format
	// ************************************************************
	typedef enum logic [1:0] {
		URS_FMT_8N = 2'b00,
		URS_FMT_8E = 2'b01,
		URS_FMT_8O = 2'b10,
		URS_FMT_9N = 2'b11
	} urs_fmt_e;

	// receiver frame states
	typedef enum logic [2:0] {
		URS_RX_IDLE,
		URS_RX_START,
		URS_RX_DATA,
		URS_RX_PARITY,
		URS_RX_STOP
	} urs_rx_state_e;

	// one fifo entry: character plus its error flags
	typedef struct packed {
		logic       parity_error_flag;
		logic       framing_error_flag;
		logic [8:0] data;
	} urs_char_s;

	function automatic logic urs_has_parity(input urs_fmt_e fmt);
		urs_has_parity = (fmt == URS_FMT_8E) || (fmt == URS_FMT_8O);
	endfunction

endpackage

// ==== src/urs_rx_fifo.sv ====
/*
 * receive buffer: four characters with their error flags.
 * assumes the caller never pushes while full.
 */
`timescale 1ns/100ps
`default_nettype none

module urs_rx_fifo
	import urs_pkg::*;
(
	input  wire logic      clk,   // peripheral clock
	input  wire logic      rst,   // synchronous reset
	input  wire logic      ce,    // clock enable
	input  wire logic      flush, // empty the buffer
	input  wire logic      push,  // write one entry
	input  wire urs_char_s wdata, // entry written
	input  wire logic      pop,   // drop the head
	output urs_char_s      head,  // entry at the head
	output logic           empty, // nothing stored
	output logic           full   // no room left
);

	urs_char_s  mem [4];
	logic [2:0] wr_reg;
	logic [2:0] rd_reg;

	assign empty = (wr_reg == rd_reg);
	assign full  = (wr_reg[1:0] == rd_reg[1:0]) && (wr_reg[2] != rd_reg[2]);
	assign head  = mem[rd_reg[1:0]];

	// ************************************************************
	// pointers; flush empties without touching storage
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst || (ce && flush)) begin
			wr_reg <= 3'h0; // see R6
			rd_reg <= 3'h0;
		end else if (ce) begin
			if (push && !full) begin
				wr_reg <= wr_reg + 3'h1;
			end
			if (pop && !empty) begin
				rd_reg <= rd_reg + 3'h1; // see R9
			end
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (ce && push && !full && !flush) begin
			mem[wr_reg[1:0]] <= wdata;
		end
	end

endmodule

`default_nettype wire

// ==== src/urs_rx_shift.sv ====
/*
 * receive shift register: frames one character off the serial line.
 * assumes rxd is already synchronous to clk and idles high.
 */
`timescale 1ns/100ps
`default_nettype none

module urs_rx_shift
	import urs_pkg::*;
(
	input  wire logic        clk,     // peripheral clock
	input  wire logic        rst,     // synchronous reset
	input  wire logic        ce,      // clock enable
	input  wire logic        flush,   // return to empty
	input  wire logic        rxd,     // serial input
	input  wire logic [15:0] bit_div, // clocks per bit, minus one
	input  wire urs_fmt_e    fmt,     // data and parity format
	output logic             busy,    // frame in progress
	output logic             done,    // character complete pulse
	output urs_char_s        chr      // character and flags
);

	urs_rx_state_e state_reg;
	logic [15:0]   cnt_reg;
	logic [3:0]    bitn_reg;
	logic [8:0]    sh_reg;
	logic          parity_error_flag_reg;
	logic          nine;

	assign nine = (fmt == URS_FMT_9N); // see R8
	assign busy = (state_reg != URS_RX_IDLE);

	// ************************************************************
	// frame sequencer
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst || (ce && flush)) begin
			state_reg <= URS_RX_IDLE; // see R6
			cnt_reg   <= 16'h0000;
			bitn_reg  <= 4'h0;
			sh_reg    <= 9'h000;
			parity_error_flag_reg  <= 1'b0;
			done      <= 1'b0;
			chr       <= '0;
		end else if (ce) begin
			// the pulse only ends on an enabled edge, so a frozen clock cannot lose it
			done <= 1'b0;
			unique case (state_reg)
			URS_RX_IDLE: begin
				if (!rxd) begin
					state_reg <= URS_RX_START;
					cnt_reg   <= {1'b0, bit_div[15:1]}; // sample mid-bit
				end
			end
			URS_RX_START: begin
				if (cnt_reg != 16'h0000) begin
					cnt_reg <= cnt_reg - 16'h0001;
				end else if (!rxd) begin
					state_reg <= URS_RX_DATA;
					cnt_reg   <= bit_div;
					bitn_reg  <= 4'h0;
				end else begin
					state_reg <= URS_RX_IDLE; // glitch, not a start bit
				end
			end
			URS_RX_DATA: begin
				if (cnt_reg != 16'h0000) begin
					cnt_reg <= cnt_reg - 16'h0001;
				end else begin
					sh_reg   <= {rxd, sh_reg[8:1]};
					cnt_reg  <= bit_div;
					bitn_reg <= bitn_reg + 4'h1;
					if (bitn_reg == (nine ? 4'h8 : 4'h7)) begin // see R8
						state_reg <= urs_has_parity(fmt) ? URS_RX_PARITY : URS_RX_STOP;
					end
				end
			end
			URS_RX_PARITY: begin
				if (cnt_reg != 16'h0000) begin
					cnt_reg <= cnt_reg - 16'h0001;
				end else begin
					// even: total ones even; odd: total ones odd
					parity_error_flag_reg  <= (^sh_reg[8:1]) ^ rxd ^ (fmt == URS_FMT_8O); // see R8
					cnt_reg   <= bit_div;
					state_reg <= URS_RX_STOP;
				end
			end
			URS_RX_STOP: begin
				if (cnt_reg != 16'h0000) begin
					cnt_reg <= cnt_reg - 16'h0001;
				end else begin
					done      <= 1'b1;
					chr.data  <= nine ? sh_reg : {1'b0, sh_reg[8:1]};
					chr.parity_error_flag  <= urs_has_parity(fmt) && parity_error_flag_reg;
					chr.framing_error_flag  <= !rxd; // stop bit must be high
					parity_error_flag_reg  <= 1'b0;
					state_reg <= URS_RX_IDLE;
				end
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== src/urs_top.sv ====
/*
 * receive status block of the serial port: register port, status and
 * control flags, address detect, overrun handling and interrupt.
 * assumes rxd is synchronous to clk and a register master that never waits.
 */
`timescale 1ns/100ps
`default_nettype none

`include "urs_defs.svh"

// Behaviour
// R1: address detect drops nine-bit characters with bit 8 low; needs nine-bit format
// R2: receiver idle flag reads one when idle, zero while receiving
// R3: parity error flag describes the character at the buffer head
// R4: framing error flag describes the character at the buffer head
// R5: overrun flag set on buffer overflow; software clears it, never sets it
// R6: clearing a set overrun flag empties buffer and shift register
// R7: data available flag reads one while the buffer holds a character
// R8: two-bit format: 11 nine/none, 10 eight/odd, 01 eight/even, 00 eight/none
// R9: error flags follow the head whenever the buffer head advances
module urs_top
	import urs_pkg::*;
(
	input  wire logic        clk,   // peripheral clock, 10 MHz
	input  wire logic        rst,   // synchronous reset, active high
	input  wire logic        ce,    // clock enable, freezes all state
	input  wire logic        rxd,   // serial receive line
	input  wire logic [7:0]  addr,  // register byte address
	input  wire logic [15:0] wdata, // register write data
	input  wire logic        wr,    // write strobe
	input  wire logic        rd,    // read strobe
	output logic      [15:0] rdata, // read data, cycle after rd
	output logic             irq    // level interrupt
);

	// ************************************************************
	// declarations
	// ************************************************************
	urs_fmt_e    fmt_reg;
	logic [15:0] div_reg;
	logic        address_detect_enable_reg;
	logic        overrun_error_flag_reg;
	logic [2:0]  ists_reg;
	logic [2:0]  imask_reg;
	logic        rx_busy;
	logic        rx_done;
	urs_char_s   rx_chr;
	urs_char_s   head;
	logic        empty;
	logic        full;
	logic        keep;
	logic        push;
	logic        ovr_evt;
	logic        overrun_error_flag_clr;
	logic        flush;
	logic        pop;
	logic [15:0] status;
	logic [2:0]  evt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ************************************************************
	// receive path
	// ************************************************************
	urs_rx_shift u_shift (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.flush   (flush),
		.rxd     (rxd),
		.bit_div (div_reg),
		.fmt     (fmt_reg),
		.busy    (rx_busy),
		.done    (rx_done),
		.chr     (rx_chr)
	);

	urs_rx_fifo u_fifo (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.flush (flush),
		.push  (push),
		.wdata (rx_chr),
		.pop   (pop),
		.head  (head),
		.empty (empty),
		.full  (full)
	);

	// address detect only filters in nine-bit format
	assign keep = !(address_detect_enable_reg && (fmt_reg == URS_FMT_9N)) || rx_chr.data[8]; // see R1

	// an accepted character with no room is an overrun and is lost
	assign push    = rx_done && keep && !full;
	assign ovr_evt = rx_done && keep && full; // see R5

	// software write of zero to a set overrun flag; a new overrun wins
	assign overrun_error_flag_clr = wr && hit(addr, `URS_OFS_STATUS)
	                  && !wdata[`URS_ST_OVERRUN_ERROR_FLAG] && overrun_error_flag_reg;
	assign flush    = overrun_error_flag_clr && !ovr_evt; // see R6

	// reading the data register consumes the head
	assign pop = rd && hit(addr, `URS_OFS_RX_DATA) && !empty; // see R9

	// ************************************************************
	// status word
	// ************************************************************
	always_comb begin
		status                 = 16'h0000;
		status[`URS_ST_ADDRESS_DETECT_ENABLE]  = address_detect_enable_reg;
		status[`URS_ST_RECEIVER_IDLE_FLAG]  = !rx_busy;             // see R2
		status[`URS_ST_PARITY_ERROR_FLAG]   = !empty && head.parity_error_flag;  // see R3
		status[`URS_ST_FRAMING_ERROR_FLAG]   = !empty && head.framing_error_flag;  // see R4
		status[`URS_ST_OVERRUN_ERROR_FLAG]   = overrun_error_flag_reg;
		status[`URS_ST_AVAIL]  = !empty;               // see R7
	end

	// ************************************************************
	// control registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			address_detect_enable_reg <= 1'b0;
		end else if (ce && wr && hit(addr, `URS_OFS_STATUS)) begin
			address_detect_enable_reg <= wdata[`URS_ST_ADDRESS_DETECT_ENABLE]; // see R1
		end
	end

	// format and bit period
	always_ff @(posedge clk) begin
		if (rst) begin
			fmt_reg <= urs_fmt_e'(`URS_RST_MODE);
			div_reg <= `URS_RST_BIT_DIV;
		end else if (ce && wr) begin
			if (hit(addr, `URS_OFS_MODE)) begin
				fmt_reg <= urs_fmt_e'(wdata[1:0]); // see R8
			end
			if (hit(addr, `URS_OFS_BIT_DIV)) begin
				div_reg <= wdata;
			end
		end
	end

	// overrun flag: hardware sets, software may only clear
	always_ff @(posedge clk) begin
		if (rst) begin
			overrun_error_flag_reg <= 1'b0;
		end else if (ce) begin
			if (ovr_evt) begin
				overrun_error_flag_reg <= 1'b1; // see R5
			end else if (overrun_error_flag_clr) begin
				overrun_error_flag_reg <= 1'b0; // see R6
			end
		end
	end

	// ************************************************************
	// interrupt status and mask
	// ************************************************************
	assign evt = {push && (rx_chr.parity_error_flag || rx_chr.framing_error_flag), ovr_evt, push};

	always_ff @(posedge clk) begin
		if (rst) begin
			ists_reg <= 3'h0;
		end else if (ce) begin
			// a new event in the clearing cycle stays set
			if (wr && hit(addr, `URS_OFS_INT_STS)) begin
				ists_reg <= (ists_reg & ~wdata[2:0]) | evt;
			end else begin
				ists_reg <= ists_reg | evt;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			imask_reg <= `URS_RST_MASK;
		end else if (ce && wr && hit(addr, `URS_OFS_INT_MASK)) begin
			imask_reg <= wdata[2:0];
		end
	end

	assign irq = |(ists_reg & imask_reg);

	// ************************************************************
	// read port: data stand one cycle after the strobe
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (ce) begin
			if (!rd) begin
				rdata <= 16'h0000;
			end else if (hit(addr, `URS_OFS_STATUS)) begin
				rdata <= status;
			end else if (hit(addr, `URS_OFS_MODE)) begin
				rdata <= {14'h0000, fmt_reg};
			end else if (hit(addr, `URS_OFS_INT_STS)) begin
				rdata <= {13'h0000, ists_reg};
			end else if (hit(addr, `URS_OFS_INT_MASK)) begin
				rdata <= {13'h0000, imask_reg};
			end else if (hit(addr, `URS_OFS_RX_DATA)) begin
				rdata <= {7'h00, head.data} & {16{!empty}};
			end else if (hit(addr, `URS_OFS_BIT_DIV)) begin
				rdata <= div_reg;
			end else begin
				rdata <= 16'h0000; // unmapped reads as zero
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_idle_flag: assert property ( // see R2
		(ce && status[`URS_ST_RECEIVER_IDLE_FLAG] && !rxd && !flush) |=> !status[`URS_ST_RECEIVER_IDLE_FLAG])
		else $error("idle flag still high after a start edge");

	a_avail_flag: assert property ( // see R7
		(ce && push && !pop && !flush) |=> status[`URS_ST_AVAIL])
		else $error("data available low after a push");

	a_parity_error_flag_head: assert property ( // see R3
		(ce && pop && u_fifo.rd_reg + 3'h1 != u_fifo.wr_reg && !push && !flush)
		|=> status[`URS_ST_PARITY_ERROR_FLAG] == $past(u_fifo.mem[u_fifo.rd_reg[1:0] + 2'h1].parity_error_flag))
		else $error("parity flag not from new head");

	a_framing_error_flag_head: assert property ( // see R4
		(ce && push && empty && !flush) |=> status[`URS_ST_FRAMING_ERROR_FLAG] == $past(rx_chr.framing_error_flag))
		else $error("framing flag not from stored character");

	a_overrun_error_flag_sets: assert property ((ce && rx_done && keep && full) |=> overrun_error_flag_reg) // see R5
		else $error("overrun not flagged");

	a_overrun_error_flag_nowrite: assert property ( // see R5
		(ce && !overrun_error_flag_reg && !ovr_evt) |=> !overrun_error_flag_reg)
		else $error("overrun flag set by software");

	a_clear_flush: assert property ( // see R6
		(ce && flush) |=> (!status[`URS_ST_AVAIL] && status[`URS_ST_RECEIVER_IDLE_FLAG]))
		else $error("overrun clear did not empty receiver");

	a_addr_drop: assert property ( // see R1
		(ce && rx_done && address_detect_enable_reg && fmt_reg == URS_FMT_9N && !rx_chr.data[8] && !flush)
		|=> $stable(u_fifo.wr_reg))
		else $error("non-address character stored");

	a_fmt_nine: assert property ( // see R8
		(ce && rx_done && fmt_reg != URS_FMT_9N) |-> !rx_chr.data[8])
		else $error("bit 8 set in eight-bit format");

	a_rd_status: assert property ( // see R9
		(ce && rd && hit(addr, `URS_OFS_STATUS)) |=> rdata[5:0] == $past(status[5:0]))
		else $error("status read returned wrong value");

	c_overrun: cover property (ce && ovr_evt);
	c_flush:   cover property (ce && flush);
	c_addr:    cover property (ce && rx_done && !keep);

endmodule

`default_nettype wire
